// ==== hdl/ccep_map.svh ====
`ifndef CCEP_MAP_SVH
`define CCEP_MAP_SVH
`define CCEP_ENPOL_OFFSET  8'h20
`define CCEP_DIRSEL_OFFSET 8'h24
`define CCEP_CTRL_OFFSET   8'h28
`define CCEP_ENPOL_RESET   32'h0000_0000
`define CCEP_ENPOL_MASK    32'h0033_3fff
`define CCEP_DIRSEL_RESET  12'h000
`define CCEP_CTRL_RESET    9'h000
`define CCEP_CTRL_MOE_BIT  0
`define CCEP_CTRL_IDLE_OFFSTATE_SELECT_BIT 1
`define CCEP_CTRL_RUN_OFFSTATE_SELECT_BIT 2
`define CCEP_DIR_OUTPUT    2'b00
`endif

// ==== hdl/ccep_pkg.sv ====
package ccep_pkg;
  // per-channel output condition derived from enable and off-state controls
  typedef enum logic [1:0] {
    CCEP_OUT_OFF    = 2'b00,
    CCEP_OUT_IDLE   = 2'b01,
    CCEP_OUT_ACTIVE = 2'b10,
    CCEP_OUT_INACT  = 2'b11
  } ccep_out_t;
endpackage : ccep_pkg

// ==== hdl/ccep_channel.sv ====
`timescale 1ns/100ps
// one channel's output gating and capture edge selection
module ccep_channel (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic is_output,
  input  wire logic enable,
  input  wire logic polarity,
  input  wire logic comp_enable,
  input  wire logic comp_polarity,
  input  wire logic main_output_enable,
  input  wire logic idle_offstate_select,
  input  wire logic run_offstate_select,
  input  wire logic idle_level,
  input  wire logic comp_idle_level,
  input  wire logic ref_level,
  input  wire logic capture_input,
  output logic      main_output,
  output logic      main_output_en,
  output logic      comp_output,
  output logic      comp_output_en,
  output logic      trigger_out,
  output logic      capture_pulse
);
  ccep_pkg::ccep_out_t main_state;
  ccep_pkg::ccep_out_t comp_state;
  logic                prev_level_reg;
  logic                trig_level;

  // trigger polarity follows the polarity bit; inverted input turns falling edges into rising
  assign trig_level = capture_input ^ polarity; // [RULE4]

  // decide state of each output; no dead-time is inserted here
  always_comb begin
    main_state = ccep_pkg::CCEP_OUT_OFF;
    comp_state = ccep_pkg::CCEP_OUT_OFF;
    if (!is_output) begin
      main_state = ccep_pkg::CCEP_OUT_OFF; // [RULE11]
      comp_state = ccep_pkg::CCEP_OUT_OFF;
    end else if (main_output_enable) begin
      if (enable) begin
        main_state = ccep_pkg::CCEP_OUT_ACTIVE; // [RULE5]
      end else if (run_offstate_select && comp_enable) begin
        main_state = ccep_pkg::CCEP_OUT_INACT;
      end
      if (comp_enable) begin
        comp_state = ccep_pkg::CCEP_OUT_ACTIVE; // [RULE2]
      end else if (run_offstate_select && enable) begin
        comp_state = ccep_pkg::CCEP_OUT_INACT;
      end
    end else if (idle_offstate_select && (enable || comp_enable)) begin
      main_state = ccep_pkg::CCEP_OUT_IDLE;
      comp_state = ccep_pkg::CCEP_OUT_IDLE;
    end
  end

  // registered pin levels; an idle pin shows its idle level, an inactive one its polarity, an off one drives 0
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      main_output    <= 1'b0;
      main_output_en <= 1'b0;
      comp_output    <= 1'b0;
      comp_output_en <= 1'b0;
    end else begin
      case (main_state)
        ccep_pkg::CCEP_OUT_ACTIVE: main_output <= ref_level ^ polarity; // [RULE3]
        ccep_pkg::CCEP_OUT_IDLE:   main_output <= idle_level;
        ccep_pkg::CCEP_OUT_INACT:  main_output <= polarity;
        default:                   main_output <= 1'b0;
      endcase
      main_output_en <= (main_state != ccep_pkg::CCEP_OUT_OFF);
      case (comp_state)
        // complementary inverts the reference when the main is also on
        ccep_pkg::CCEP_OUT_ACTIVE: comp_output <= (enable ? ~ref_level : ref_level) ^ comp_polarity; // [RULE1]
        ccep_pkg::CCEP_OUT_IDLE:   comp_output <= comp_idle_level;
        ccep_pkg::CCEP_OUT_INACT:  comp_output <= comp_polarity;
        default:                   comp_output <= 1'b0;
      endcase
      comp_output_en <= (comp_state != ccep_pkg::CCEP_OUT_OFF);
    end
  end

  // edge detect on the polarised input; history runs even while disabled so enabling is glitch free
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_level_reg <= 1'b0;
      capture_pulse  <= 1'b0;
      trigger_out    <= 1'b0;
    end else begin
      prev_level_reg <= trig_level;
      capture_pulse  <= !is_output && enable && trig_level && !prev_level_reg; // [RULE6] [RULE4]
      trigger_out    <= trig_level;
    end
  end
endmodule : ccep_channel

// ==== hdl/ccep_top.sv ====
`timescale 1ns/100ps
`include "ccep_map.svh"
// Contract
// RULE1 - the complementary polarity bit makes the complementary output active high when clear, low when set.
// RULE2 - the complementary enable bit drives the complementary output, qualified by main enable and off-states.
// RULE3 - in output mode the polarity bit makes the main output active high when clear, low when set.
// RULE4 - in input mode a clear polarity captures rising edges, a set one falling edges and inverts the trigger.
// RULE5 - in output mode the enable bit drives the main output, qualified by main enable and off-states.
// RULE6 - in input mode the enable bit allows capture when set and blocks it when clear.
// RULE7 - channels 2 and 3 repeat channel 1's four bits at bits 4 to 7 and 8 to 11.
// RULE8 - channels 4, 5 and 6 have enable and polarity at bits 12/13, 16/17 and 20/21.
// RULE9 - software keeps reserved bits 31:22, 19:18 and 15:14 at zero.
// RULE10 - on reset the enable and polarity register clears to zero.
// RULE11 - direction code 00 means output, any other code input, and picks what the bits act on.
// RULE12 - a channel's direction code is writable only while its enable bit is clear.
// RULE13 - a register write takes effect at the next clock edge with no shadow stage.
module ccep_top #(
  parameter int NUM_CH = 6
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [31:0]       rdata,
  input  wire logic [NUM_CH-1:0] ref_level,
  input  wire logic [NUM_CH-1:0] capture_input,
  output logic      [NUM_CH-1:0] main_output,
  output logic      [NUM_CH-1:0] main_output_en,
  output logic      [2:0]        comp_output,
  output logic      [2:0]        comp_output_en,
  output logic      [NUM_CH-1:0] trigger_out,
  output logic      [NUM_CH-1:0] capture_pulse
);
  logic [31:0]       channel_enable_polarity_reg;
  logic [11:0]       direction_select_reg;
  logic [8:0]        control_reg;
  logic [NUM_CH-1:0] en_bit;
  logic [NUM_CH-1:0] pol_bit;
  logic [NUM_CH-1:0] cen_bit;
  logic [NUM_CH-1:0] cpol_bit;
  logic [NUM_CH-1:0] is_output;
  logic [2:0]        comp_out_w;
  logic [2:0]        comp_en_w;
  logic [NUM_CH-1:0] comp_out_all;
  logic [NUM_CH-1:0] comp_en_all;

  // direct write, no preload; reserved bits are forced to zero on write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_enable_polarity_reg <= `CCEP_ENPOL_RESET; // [RULE10]
    end else if (wr_stb && addr == `CCEP_ENPOL_OFFSET) begin
      channel_enable_polarity_reg <= wdata & `CCEP_ENPOL_MASK; // [RULE13] [RULE9]
    end
  end

  // direction codes, two bits per channel; locked per channel while its enable is set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      direction_select_reg <= `CCEP_DIRSEL_RESET;
    end else if (wr_stb && addr == `CCEP_DIRSEL_OFFSET) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!en_bit[i]) begin
          direction_select_reg[2*i +: 2] <= wdata[2*i +: 2]; // [RULE12]
        end
      end
    end
  end

  // main output enable, off-state selects and idle levels of channels 1 to 3
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= `CCEP_CTRL_RESET;
    end else if (wr_stb && addr == `CCEP_CTRL_OFFSET) begin
      control_reg <= wdata[8:0];
    end
  end

  // read data valid in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (addr)
        `CCEP_ENPOL_OFFSET:  rdata <= channel_enable_polarity_reg;
        `CCEP_DIRSEL_OFFSET: rdata <= {20'h0_0000, direction_select_reg};
        `CCEP_CTRL_OFFSET:   rdata <= {23'h00_0000, control_reg};
        default:             rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // field extraction: chans 0-2 use four bits each, chans 3-5 sit at 12, 16, 20
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam int BASE = (c < 3) ? 4*c : 12 + 4*(c-3);
      assign en_bit[c]    = channel_enable_polarity_reg[BASE];   // [RULE7] [RULE8]
      assign pol_bit[c]   = channel_enable_polarity_reg[BASE+1];
      assign cen_bit[c]   = (c < 3) ? channel_enable_polarity_reg[BASE+2] : 1'b0;
      assign cpol_bit[c]  = (c < 3) ? channel_enable_polarity_reg[BASE+3] : 1'b0;
      assign is_output[c] = (direction_select_reg[2*c +: 2] == `CCEP_DIR_OUTPUT); // [RULE11]
      ccep_channel u_ch (
        .mclk                 (mclk),
        .rst_n                (rst_n),
        .is_output            (is_output[c]),
        .enable               (en_bit[c]),
        .polarity             (pol_bit[c]),
        .comp_enable          (cen_bit[c]),
        .comp_polarity        (cpol_bit[c]),
        .main_output_enable   (control_reg[`CCEP_CTRL_MOE_BIT]),
        .idle_offstate_select (control_reg[`CCEP_CTRL_IDLE_OFFSTATE_SELECT_BIT]),
        .run_offstate_select  (control_reg[`CCEP_CTRL_RUN_OFFSTATE_SELECT_BIT]),
        .idle_level           ((c < 3) ? control_reg[(c < 3) ? 3+2*c : 3] : 1'b0),
        .comp_idle_level      ((c < 3) ? control_reg[(c < 3) ? 4+2*c : 4] : 1'b0),
        .ref_level            (ref_level[c]),
        .capture_input        (capture_input[c]),
        .main_output          (main_output[c]),
        .main_output_en       (main_output_en[c]),
        .comp_output          (comp_out_all[c]),
        .comp_output_en       (comp_en_all[c]),
        .trigger_out          (trigger_out[c]),
        .capture_pulse        (capture_pulse[c])
      );
    end
  endgenerate

  // channels 4 to 6 have no complementary pin
  assign comp_out_w     = comp_out_all[2:0];
  assign comp_en_w      = comp_en_all[2:0];
  assign comp_output    = comp_out_w;
  assign comp_output_en = comp_en_w;
endmodule : ccep_top

// ==== test/ccep_top_sva.sv ====
`timescale 1ns/100ps
// watches register traffic and channel outputs at the top ports
module ccep_top_sva #(
  parameter int NUM_CH = 6
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [7:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [31:0]       rdata,
  input wire logic [NUM_CH-1:0] capture_input,
  input wire logic [NUM_CH-1:0] main_output_en,
  input wire logic [2:0]        comp_output_en,
  input wire logic [NUM_CH-1:0] trigger_out,
  input wire logic [NUM_CH-1:0] capture_pulse
);
  logic [31:0]       sh_reg;
  logic [NUM_CH-1:0] en, pol;
  logic [2:0]        ce;
  // shadow of the enable/polarity word, so gating can be judged from the bus alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sh_reg <= 32'h0;
    else if (wr_stb && addr == 8'h20) sh_reg <= wdata & 32'h0033_3fff;
  end
  assign en  = {sh_reg[20], sh_reg[16], sh_reg[12], sh_reg[8], sh_reg[4], sh_reg[0]};
  assign pol = {sh_reg[21], sh_reg[17], sh_reg[13], sh_reg[9], sh_reg[5], sh_reg[1]};
  assign ce  = {sh_reg[10], sh_reg[6], sh_reg[2]};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reserved_zero_a: assert property (rd_stb |=> (rdata & ~32'h0033_3fff) == 32'h0)
    else $error("reserved bits read nonzero");
  readback_a: assert property (rd_stb && addr == 8'h20 |=> rdata == sh_reg)
    else $error("readback differs from written word");
  write_now_a: assert property (wr_stb && addr == 8'h20 ##1 rd_stb && addr == 8'h20
    |=> rdata == ($past(wdata, 2) & 32'h0033_3fff)) else $error("write not visible at once");
  trig_pol_a: assert property (trigger_out == $past(capture_input ^ pol))
    else $error("trigger polarity wrong");
  cap_gate_a: assert property ((capture_pulse & ~$past(en)) == '0)
    else $error("capture while disabled");
  cap_once_a: assert property ((capture_pulse & $past(capture_pulse)) == '0)
    else $error("capture pulse too long");
  main_gate_a: assert property ((main_output_en & ~$past(en | {3'b000, ce})) == '0)
    else $error("main output driven with channel off");
  comp_gate_a: assert property ((comp_output_en & ~$past(en[2:0] | ce)) == '0)
    else $error("comp output driven with channel off");
endmodule : ccep_top_sva
bind ccep_top ccep_top_sva #(.NUM_CH(NUM_CH)) u_sva (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .capture_input(capture_input),
  .main_output_en(main_output_en), .comp_output_en(comp_output_en), .trigger_out(trigger_out),
  .capture_pulse(capture_pulse));

// ==== test/capture_compare_enable_polarity_tb.sv ====
`timescale 1ns/100ps
module capture_compare_enable_polarity_tb;
  logic        mclk, rst_n, wr_stb, rd_stb;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, v;
  logic [5:0]  ref_level, capture_input, main_output, main_output_en, trigger_out, capture_pulse;
  logic [2:0]  comp_output, comp_output_en, cnt;
  int          mismatches, tests_run;
  ccep_top dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .ref_level(ref_level), .capture_input(capture_input), .main_output(main_output),
    .main_output_en(main_output_en), .comp_output(comp_output), .comp_output_en(comp_output_en),
    .trigger_out(trigger_out), .capture_pulse(capture_pulse));
  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] masked(logic [31:0] x);
    return x & 32'h0033_3fff; // reserved bits never stick
  endfunction : masked
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] x);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= x;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(logic [7:0] a, output logic [31:0] x);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 x = rdata;
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // watchdog: a hang counts as a failure
  initial begin
    #100us;
    mismatches++;
    end_sim();
  end
  // main sequence
  initial begin
    {rst_n, wr_stb, rd_stb, addr, wdata, ref_level, capture_input} = '0;
    void'($urandom(32'h767bcce9));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h20, d);
    chk("enpol_reset", d, 32'h0);
    rd(8'h30, d);
    chk("unmapped", d, 32'h0);
    for (int n = 0; n < 24; n++) begin
      v = (n == 0) ? 32'hffff_ffff : $urandom;
      wr(8'h20, v);
      rd(8'h20, d);
      chk("enpol", d, masked(v));
    end
    wr(8'h20, 32'h0);
    wr(8'h28, 32'h1);
    // main only, then comp only, every polarity, random reference
    for (int n = 0; n < 8; n++) begin
      ref_level <= 6'($urandom);
      wr(8'h20, n[2] ? ((n[1] << 3) | 32'h4) : ((n[0] << 1) | 32'h1));
      repeat (2) @(posedge mclk);
      #1;
      if (n[2]) chk("comp", {comp_output_en[0], comp_output[0]}, {1'b1, ref_level[0] ^ n[1]});
      else chk("main", {main_output_en[0], main_output[0]}, {1'b1, ref_level[0] ^ n[0]});
    end
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h1);
    rd(8'h24, d);
    chk("dir_locked", d, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h1);
    rd(8'h24, d);
    chk("dir_open", d, 32'h1);
    // input mode: each polarity, capture enabled and blocked
    for (int n = 0; n < 4; n++) begin
      wr(8'h20, (n[1] << 1) | n[0]);
      capture_input[0] <= n[1];
      repeat (3) @(posedge mclk);
      capture_input[0] <= ~n[1];
      cnt = 3'h0;
      repeat (4) begin
        @(posedge mclk);
        #1 cnt = cnt + capture_pulse[0];
      end
      chk("capture", cnt, n[0]);
      chk("trigger", trigger_out[0], 1'b1);
      chk("in_mode_off", main_output_en[0], 1'b0);
    end
    end_sim();
  end
endmodule : capture_compare_enable_polarity_tb
